// file: hdl/sfc_map.vh
// Address map, field positions and timing counts of the flash controller
`ifndef SFC_MAP_VH
`define SFC_MAP_VH

// ==========================================================
// Address map
`define SFC_INFO_LO        16'h1000
`define SFC_INFO_HI        16'h10ff
`define SFC_MAIN_LO        16'h1100
`define SFC_MAIN_HI        16'hffff
`define SFC_INFO_SEG_BYTES 64
`define SFC_MAIN_SEG_BYTES 512
`define SFC_INFO_SEG_SH    6
`define SFC_MAIN_SEG_SH    9
`define SFC_SEG_A_IDX      2'h3

// ==========================================================
// Calibration records in segment A
`define SFC_TAG_OSC_ADDR   16'h10f6
`define SFC_TAG_CONV_ADDR  16'h10da
`define SFC_TAG_OSC_VAL    8'h01
`define SFC_TAG_CONV_VAL   8'h10
`define SFC_TAG_EMPTY      8'hfe
`define SFC_OSC_REC_FIRST  16'h0000
`define SFC_OSC_REC_LAST   16'h0007

// ==========================================================
// Commands
`define SFC_CMD_PROG       3'h0
`define SFC_CMD_ERASE_SEG  3'h1
`define SFC_CMD_ERASE_MAIN 3'h2
`define SFC_CMD_ERASE_ALL  3'h3

// ==========================================================
// Sources
`define SFC_SRC_CPU        2'h0
`define SFC_SRC_LOADER     2'h1
`define SFC_SRC_JTAG       2'h2

// ==========================================================
// Timing
`define SFC_CLK_MHZ        100
`define SFC_PROG_US        30
`define SFC_ERASE_US       5000
`define SFC_PROG_CYC       (`SFC_PROG_US * `SFC_CLK_MHZ)
`define SFC_ERASE_CYC      (`SFC_ERASE_US * `SFC_CLK_MHZ)

`endif

// file: hdl/sfc_timer.v
// Operation duration timer of the flash controller
`timescale 1ns/1ps
`default_nettype none

module sfc_timer #(
  parameter CW = 20
) (
  // Clock and reset
  input  wire          clk,
  input  wire          resetn,
  // Control
  input  wire          start,
  input  wire [CW-1:0] count,
  // Status
  output wire          done
);

  reg [CW-1:0] cnt_q;
  reg          run_q;

  // ==========================================================
  // Down counter
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= {CW{1'b0}};
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= count;
      run_q <= 1'b1;
    end else if (run_q) begin
      if (cnt_q <= {{(CW-1){1'b0}}, 1'b1})
        run_q <= 1'b0;
      else
        cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  assign done = run_q && (cnt_q <= {{(CW-1){1'b0}}, 1'b1});

endmodule

`default_nettype wire

// file: hdl/sfc_ctrl.v
// Segmented flash array with program and erase sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sfc_map.vh"

module sfc_ctrl #(
  parameter AW        = 16,
  parameter PROG_CYC  = `SFC_PROG_CYC,
  parameter ERASE_CYC = `SFC_ERASE_CYC
) (
  // Clock and reset
  input  wire          clk,
  input  wire          resetn,
  // CPU request port
  input  wire          cpu_req,
  input  wire [2:0]    cpu_cmd,
  input  wire          cpu_word,
  input  wire [AW-1:0] cpu_addr,
  input  wire [15:0]   cpu_wdata,
  // Serial boot loader request port
  input  wire          serial_boot_loader_req,
  input  wire [2:0]    serial_boot_loader_cmd,
  input  wire          serial_boot_loader_word,
  input  wire [AW-1:0] serial_boot_loader_addr,
  input  wire [15:0]   serial_boot_loader_wdata,
  // JTAG request port
  input  wire          jtag_req,
  input  wire [2:0]    jtag_cmd,
  input  wire          jtag_word,
  input  wire [AW-1:0] jtag_addr,
  input  wire [15:0]   jtag_wdata,
  // Read port
  input  wire          rd_en,
  input  wire [AW-1:0] rd_addr,
  input  wire          margin_en,
  output reg  [15:0]   rd_data,
  output reg           rd_margin_fail,
  // Control and status
  input  wire          seg_a_unlock,
  input  wire          seg_a_relock,
  input  wire          viol_clear,
  input  wire          viol_ie,
  output wire          busy,
  output wire          seg_a_locked,
  output wire          access_violation_flag,
  output wire          nmi_req,
  output reg           op_done
);

  localparam CW = 24;
  localparam [CW-1:0] PROG_N  = PROG_CYC;
  localparam [CW-1:0] ERASE_N = ERASE_CYC;

  // One-hot sequencer states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PROG = 3'b010;
  localparam [2:0] ST_ERAS = 3'b100;

  // ==========================================================
  // Storage
  // Trade-off: flip-flop array for the full space, fine for
  // simulation; a real macro replaces it.
  reg [7:0]    mem_q [0:(1<<AW)-1];
  reg [2:0]    st_q;
  reg [2:0]    cmd_q;
  reg          word_q;
  reg [AW-1:0] addr_q;
  reg [15:0]   wdata_q;
  reg          lock_q;
  reg          viol_q;
  reg          t_start;
  reg [CW-1:0] t_count;
  wire         t_done;

  // ==========================================================
  // Address decode
  // info and main ranges
  function is_info;
    input [AW-1:0] a;
    begin
      is_info = (a >= `SFC_INFO_LO) && (a <= `SFC_INFO_HI);
    end
  endfunction

  function is_main;
    input [AW-1:0] a;
    begin
      is_main = (a >= `SFC_MAIN_LO);
    end
  endfunction

  // segment A is the top info segment
  function is_seg_a;
    input [AW-1:0] a;
    begin
      is_seg_a = is_info(a) &&
                 (a[7:`SFC_INFO_SEG_SH] == `SFC_SEG_A_IDX);
    end
  endfunction

  // Is byte b inside the erase target of the held command
  function in_erase;
    input [2:0]    c;
    input [AW-1:0] t;
    input [AW-1:0] b;
    begin
      case (c)
        `SFC_CMD_ERASE_SEG:
          in_erase = is_info(t) ?
            (is_info(b) &&
             b[AW-1:`SFC_INFO_SEG_SH] == t[AW-1:`SFC_INFO_SEG_SH]) :
            (is_main(b) &&
             b[AW-1:`SFC_MAIN_SEG_SH] == t[AW-1:`SFC_MAIN_SEG_SH]);
        `SFC_CMD_ERASE_MAIN:
          in_erase = is_main(b);
        // combined erase, lock still guards segment A
        `SFC_CMD_ERASE_ALL:
          in_erase = is_main(b) || (is_info(b) && !is_seg_a(b)) ||
                     (is_seg_a(b) && !lock_q);
        default:
          in_erase = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // Source arbitration
  // JTAG first, then boot loader, then CPU
  reg          req;
  reg [2:0]    req_cmd;
  reg          req_word;
  reg [AW-1:0] req_addr;
  reg [15:0]   req_wdata;

  always @* begin
    req       = 1'b1;
    req_cmd   = jtag_cmd;
    req_word  = jtag_word;
    req_addr  = jtag_addr;
    req_wdata = jtag_wdata;
    if (jtag_req) begin
      req = 1'b1;
    end else if (serial_boot_loader_req) begin
      req_cmd   = serial_boot_loader_cmd;
      req_word  = serial_boot_loader_word;
      req_addr  = serial_boot_loader_addr;
      req_wdata = serial_boot_loader_wdata;
    end else if (cpu_req) begin
      req_cmd   = cpu_cmd;
      req_word  = cpu_word;
      req_addr  = cpu_addr;
      req_wdata = cpu_wdata;
    end else begin
      req = 1'b0;
    end
  end

  // Request checks
  wire req_prog = (req_cmd == `SFC_CMD_PROG);
  wire req_seg  = (req_cmd == `SFC_CMD_ERASE_SEG);
  wire req_known = req_cmd <= `SFC_CMD_ERASE_ALL;
  wire req_misal = req_prog && req_word && req_addr[0];
  wire req_outside = (req_prog || req_seg) &&
                     !is_info(req_addr) && !is_main(req_addr);
  wire req_lock_hit = lock_q && (req_prog || req_seg) &&
                      (is_seg_a(req_addr) ||
                       (req_prog && req_word &&
                        is_seg_a(req_addr + {{(AW-1){1'b0}}, 1'b1})));
  wire req_bad  = !req_known || req_misal || req_outside || req_lock_hit;
  wire idle     = (st_q == ST_IDLE);
  wire accept   = req && idle && !req_bad;
  // requests while busy are dropped, not flagged
  wire refuse   = req && idle && req_bad;

  // ==========================================================
  // Sequencer
  always @* begin
    t_start = accept;
    t_count = req_prog ? PROG_N : ERASE_N;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q    <= ST_IDLE;
      cmd_q   <= 3'h0;
      word_q  <= 1'b0;
      addr_q  <= {AW{1'b0}};
      wdata_q <= 16'h0000;
      op_done <= 1'b0;
    end else begin
      op_done <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (accept) begin
            cmd_q   <= req_cmd;
            word_q  <= req_word;
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
            st_q    <= req_prog ? ST_PROG : ST_ERAS;
          end
        end
        ST_PROG, ST_ERAS: begin
          if (t_done) begin
            st_q    <= ST_IDLE;
            op_done <= 1'b1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign busy = !idle;

  // ==========================================================
  // Array update at end of operation
  // Flash programming only clears bits, hence the AND.
  integer i;
  always @(posedge clk) begin
    if (t_done && st_q == ST_PROG) begin
      mem_q[addr_q] <= mem_q[addr_q] & wdata_q[7:0];
      if (word_q)
        mem_q[addr_q + {{(AW-1){1'b0}}, 1'b1}] <=
          mem_q[addr_q + {{(AW-1){1'b0}}, 1'b1}] & wdata_q[15:8];
    end else if (t_done && st_q == ST_ERAS) begin
      for (i = 0; i < (1 << AW); i = i + 1)
        if (in_erase(cmd_q, addr_q, i[AW-1:0]))
          mem_q[i] <= 8'hff;
    end
  end

  // ==========================================================
  // Segment A lock
  // locked at reset, released by software only
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      lock_q <= 1'b1;
    else if (seg_a_relock)
      lock_q <= 1'b1;
    else if (seg_a_unlock && idle)
      lock_q <= 1'b0;
  end
  assign seg_a_locked = lock_q;

  // ==========================================================
  // Access violation
  // set wins over clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      viol_q <= 1'b0;
    else if (refuse)
      viol_q <= 1'b1;
    else if (viol_clear)
      viol_q <= 1'b0;
  end
  assign access_violation_flag = viol_q;
  // own enable gates the NMI request
  assign nmi_req = viol_q && viol_ie;

  // ==========================================================
  // Read path
  // margin read: flags a byte at rd_addr that holds unknown bits
  // records read from segment A as stored
  wire [AW-1:0] rd_next = rd_addr + {{(AW-1){1'b0}}, 1'b1};
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data        <= 16'h0000;
      rd_margin_fail <= 1'b0;
    end else if (rd_en) begin
      rd_data        <= {mem_q[rd_next], mem_q[rd_addr]};
      rd_margin_fail <= margin_en &&
                        ((^mem_q[rd_addr]) === 1'bx);
    end
  end

  // ==========================================================
  // Initial contents: erased array with calibration records
  // tags and four oscillator pairs; values arbitrary
  integer k;
  initial begin
    for (k = 0; k < (1 << AW); k = k + 1)
      mem_q[k] = 8'hff;
    mem_q[`SFC_TAG_OSC_ADDR]  = `SFC_TAG_OSC_VAL;
    mem_q[`SFC_TAG_OSC_ADDR + 1] = 8'h08;
    for (k = `SFC_OSC_REC_FIRST; k <= `SFC_OSC_REC_LAST; k = k + 1)
      mem_q[`SFC_TAG_OSC_ADDR + 2 + k] = 8'h80;
    mem_q[`SFC_TAG_CONV_ADDR] = `SFC_TAG_CONV_VAL;
    mem_q[`SFC_TAG_CONV_ADDR + 1] = 8'h10;
    mem_q[`SFC_INFO_LO] = `SFC_TAG_EMPTY;
  end

  // ==========================================================
  // Duration timer
  sfc_timer #(
    .CW     (CW)
  ) u_timer (
    .clk    (clk),
    .resetn (resetn),
    .start  (t_start),
    .count  (t_count),
    .done   (t_done)
  );

endmodule

`default_nettype wire

// file: verif/sfc_ctrl_assertions.sv
// Port checker for the flash controller
`timescale 1ns/1ps
`default_nettype none
module sfc_ctrl_assertions #(
  parameter PROG_CYC  = 4,
  parameter ERASE_CYC = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Requests
  input wire logic cpu_req,
  input wire logic serial_boot_loader_req,
  input wire logic jtag_req,
  // Control and status
  input wire logic seg_a_unlock,
  input wire logic seg_a_relock,
  input wire logic viol_clear,
  input wire logic viol_ie,
  input wire logic busy,
  input wire logic seg_a_locked,
  input wire logic access_violation_flag,
  input wire logic nmi_req,
  input wire logic op_done
);
  // ==========================================================
  // Busy length counter
  logic [19:0] cnt_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cnt_q <= '0;
    else cnt_q <= busy ? cnt_q + 20'h1 : 20'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Properties
  op_len_a: assert property (
    op_done |-> (cnt_q == PROG_CYC || cnt_q == ERASE_CYC))
    else $error("operation length wrong");
  done_pulse_a: assert property (op_done |=> !op_done)
    else $error("done longer than one cycle");
  busy_end_a: assert property (op_done |-> !busy)
    else $error("busy after done");
  busy_hold_a: assert property (busy |=> busy || op_done)
    else $error("busy dropped early");
  idle_stay_a: assert property (
    !busy && !cpu_req && !serial_boot_loader_req && !jtag_req |=> !busy)
    else $error("busy without request");
  lock_hold_a: assert property (
    seg_a_locked && !seg_a_unlock |=> seg_a_locked)
    else $error("lock lost");
  relock_set_a: assert property (seg_a_relock |=> seg_a_locked)
    else $error("relock ignored");
  flag_hold_a: assert property (
    access_violation_flag && !viol_clear |=> access_violation_flag)
    else $error("flag lost");
  nmi_gate_a: assert property (
    nmi_req == (access_violation_flag && viol_ie))
    else $error("nmi request wrong");
  viol_idle_a: assert property (
    $rose(access_violation_flag) |-> !$past(busy))
    else $error("flag raised while busy");
  viol_cause_a: assert property (
    $rose(access_violation_flag) |->
      ($past(cpu_req) || $past(serial_boot_loader_req) || $past(jtag_req)))
    else $error("flag raised without request");
endmodule
bind sfc_ctrl sfc_ctrl_assertions #(
  .PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) i_chk (
  .clk(clk), .resetn(resetn), .cpu_req(cpu_req),
  .serial_boot_loader_req(serial_boot_loader_req), .jtag_req(jtag_req),
  .seg_a_unlock(seg_a_unlock), .seg_a_relock(seg_a_relock),
  .viol_clear(viol_clear), .viol_ie(viol_ie), .busy(busy),
  .seg_a_locked(seg_a_locked), .nmi_req(nmi_req), .op_done(op_done),
  .access_violation_flag(access_violation_flag));
`default_nettype wire

// file: verif/sfc_req_agent.sv
// Request source model for one programming port
`timescale 1ns/1ps
`default_nettype none
module sfc_req_agent (
  // Clock and status
  input  wire logic        clk,
  input  wire logic        busy,
  // Request
  output var  logic        req,
  output var  logic [2:0]  cmd,
  output var  logic        word,
  output var  logic [15:0] addr,
  output var  logic [15:0] wdata
);
  initial {req, cmd, word, addr, wdata} = '0;
  task automatic send(input logic [2:0] c, input logic w,
                      input logic [15:0] a, d, input bit one);
    int i;
    @(posedge clk);
    #1;
    {req, cmd, word, addr, wdata} = {1'b1, c, w, a, d};
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (busy === 1'b0 || one) break;
    end
    #1;
    req = 1'b0;
    // Released address and data lines must not keep stale values
    addr = ~a;
    wdata = ~d;
  endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking testbench of the flash controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, resetn, rd_en, margin_en, seg_a_unlock, seg_a_relock;
  logic viol_clear, viol_ie, rd_margin_fail, busy, seg_a_locked;
  logic access_violation_flag, nmi_req, op_done;
  logic [15:0] rd_addr, rd_data, v, w;
  logic c_req, l_req, j_req, c_wd, l_wd, j_wd;
  logic [2:0] c_cmd, l_cmd, j_cmd;
  logic [15:0] c_a, l_a, j_a, c_d, l_d, j_d;
  int err_total, total_checks;
  // Operation lengths used in simulation
  localparam int PC = 4;
  localparam int EC = 8;
  initial clk = 0;
  always #5 clk = ~clk;
  sfc_req_agent i_cpu (.clk(clk), .busy(busy), .req(c_req), .cmd(c_cmd),
    .word(c_wd), .addr(c_a), .wdata(c_d));
  sfc_req_agent i_ldr (.clk(clk), .busy(busy), .req(l_req), .cmd(l_cmd),
    .word(l_wd), .addr(l_a), .wdata(l_d));
  sfc_req_agent i_jtg (.clk(clk), .busy(busy), .req(j_req), .cmd(j_cmd),
    .word(j_wd), .addr(j_a), .wdata(j_d));
  sfc_ctrl #(.PROG_CYC(PC), .ERASE_CYC(EC)) i_dut (
    .clk(clk), .resetn(resetn), .cpu_req(c_req), .cpu_cmd(c_cmd),
    .cpu_word(c_wd), .cpu_addr(c_a), .cpu_wdata(c_d),
    .serial_boot_loader_req(l_req), .serial_boot_loader_cmd(l_cmd),
    .serial_boot_loader_word(l_wd), .serial_boot_loader_addr(l_a),
    .serial_boot_loader_wdata(l_d), .jtag_req(j_req), .jtag_cmd(j_cmd),
    .jtag_word(j_wd), .jtag_addr(j_a), .jtag_wdata(j_d),
    .rd_en(rd_en), .rd_addr(rd_addr), .margin_en(margin_en),
    .rd_data(rd_data), .rd_margin_fail(rd_margin_fail),
    .seg_a_unlock(seg_a_unlock), .seg_a_relock(seg_a_relock),
    .viol_clear(viol_clear), .viol_ie(viol_ie), .busy(busy),
    .seg_a_locked(seg_a_locked), .nmi_req(nmi_req), .op_done(op_done),
    .access_violation_flag(access_violation_flag));
  // ==========================================================
  // Helpers
  task chk(input logic [15:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      $display("BAD t=%0t %s got %h", $time, m, g);
      err_total++;
    end
  endtask
  task rd(input logic [15:0] a);
    @(posedge clk); #1 rd_en = 1; rd_addr = a;
    @(posedge clk); #1 rd_en = 0; rd_addr = ~a; v = rd_data;
  endtask
  task fin(input int n);
    int i;
    for (i = 0; i < 40 && op_done !== 1'b1; i++) begin
      @(posedge clk); #1;
    end
    chk(op_done, 1, "no done pulse");
    chk(i, n, "operation length");
    @(posedge clk); #1;
    chk(op_done, 0, "done too long");
    chk(busy, 0, "busy after done");
  endtask
  task clr;
    @(posedge clk); #1 viol_clear = 1;
    @(posedge clk); #1 viol_clear = 0;
  endtask
  task bad(input logic [2:0] c, input logic wd, input logic [15:0] a);
    i_cpu.send(c, wd, a, 16'h0, 0);
    @(posedge clk); #1;
    chk(access_violation_flag, 1, "illegal not flagged");
    chk(busy, 0, "illegal started");
    clr;
    chk(access_violation_flag, 0, "flag not cleared");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task t_main;
    rd(16'h10f6); chk(v[7:0], 8'h01, "osc tag");
    rd(16'h10da); chk(v[7:0], 8'h10, "conv tag");
    i_cpu.send(3'h0, 1, 16'hfffe, 16'h1234, 0); fin(PC);
    rd(16'hfffe); chk(v, 16'h1234, "top word");
    i_cpu.send(3'h2, 0, 16'h1100, 16'h0, 0); fin(EC);
    rd(16'hfffe); chk(v, 16'hffff, "mass erase");
    rd(16'h10f6); chk(v[7:0], 8'h01, "info kept");
    i_ldr.send(3'h0, 1, 16'h1200, 16'ha5c3, 0); fin(PC);
    i_cpu.send(3'h0, 0, 16'h1400, 16'h003c, 0); fin(PC);
    i_jtg.send(3'h0, 0, 16'h11ff, 16'h0096, 0); fin(PC);
    rd(16'h1200); chk(v, 16'ha5c3, "word program");
    i_jtg.send(3'h1, 0, 16'h1300, 16'h0, 0); fin(EC);
    rd(16'h1200); chk(v, 16'hffff, "segment erase");
    rd(16'h1400); chk(v[7:0], 8'h3c, "next segment");
    rd(16'h11fe); chk(v[15:8], 8'h96, "previous segment");
    margin_en = 1;
    rd(16'h1400); chk(rd_margin_fail, 0, "margin read");
    margin_en = 0;
    $display("main array test done");
  endtask
  task t_info;
    i_ldr.send(3'h3, 0, 16'h1000, 16'h0, 0); fin(EC);
    rd(16'h1000); chk(v, 16'hffff, "all erase info");
    rd(16'h1400); chk(v, 16'hffff, "all erase main");
    rd(16'h10f6); chk(v[7:0], 8'h01, "locked A kept");
    i_cpu.send(3'h0, 0, 16'h1000, 16'h0011, 0); fin(PC);
    i_cpu.send(3'h0, 0, 16'h1040, 16'h0022, 0); fin(PC);
    i_jtg.send(3'h1, 0, 16'h107f, 16'h0, 0); fin(EC);
    rd(16'h1040); chk(v, 16'hffff, "info erase");
    rd(16'h1000); chk(v[7:0], 8'h11, "info neighbour");
    $display("info segment test done");
  endtask
  task t_lock;
    chk(seg_a_locked, 1, "lock after reset");
    rd(16'h10c0); w = v;
    viol_ie = 1;
    i_cpu.send(3'h0, 1, 16'h10c0, 16'h0000, 0);
    @(posedge clk); #1;
    chk(access_violation_flag, 1, "lock hit flag");
    chk(busy, 0, "lock hit started");
    chk(nmi_req, 1, "nmi raised");
    viol_ie = 0;
    #1 chk(nmi_req, 0, "nmi masked");
    rd(16'h10c0); chk(v, w, "locked contents");
    clr;
    @(posedge clk); #1 seg_a_unlock = 1;
    @(posedge clk); #1 seg_a_unlock = 0;
    chk(seg_a_locked, 0, "unlock");
    i_cpu.send(3'h0, 1, 16'h10c0, 16'h0000, 0); fin(PC);
    rd(16'h10c0); chk(v, 16'h0000, "unlocked write");
    @(posedge clk); #1 seg_a_relock = 1;
    @(posedge clk); #1 seg_a_relock = 0;
    chk(seg_a_locked, 1, "relock");
    $display("lock test done");
  endtask
  task t_busy;
    i_cpu.send(3'h0, 1, 16'h1500, 16'h00ff, 0);
    chk(busy, 1, "busy after take");
    i_jtg.send(3'h0, 1, 16'h1502, 16'h0000, 1); fin(PC - 2);
    rd(16'h1502); chk(v, 16'hffff, "request while busy");
    rd(16'h1500); chk(v, 16'h00ff, "first write");
    $display("busy test done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    {resetn, rd_en, margin_en, seg_a_unlock, seg_a_relock} = '0;
    {viol_clear, viol_ie, rd_addr} = '0;
    err_total = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    #1 resetn = 1;
    t_main;
    t_info;
    t_lock;
    bad(3'h0, 1, 16'h1101);
    bad(3'h5, 0, 16'h1100);
    bad(3'h0, 0, 16'h0200);
    $display("illegal request test done");
    t_busy;
    tally_and_finish;
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
